// ### logic/tirpg_pkg.sv
/*
  constants, field positions, reset values and shared types of the timer
  group and infrared/pwm waveform generator.
  assumes an 8-bit register port with one-cycle strobes.
*/
// Behaviour
// R1 - carrier mode 0: output high and low times come from two width counters; here one counter, width_cnt_r, is reloaded from either width
// R2 - carrier mode 1: low segments are modulated by the carrier
// R3 - long pulse 0 uses both widths; 1 ignores high width, one pulse
// R4 - pin select 0 keeps the port pin; 1 routes the modulator output
// R5 - software sets the pin direction bit to output for modulator use
// R6 - mask register holds one enable per source, 1 enables
// R7 - software always writes zero to mask bit 2
// R8 - a source requests only while its enable bit is 1
// R9 - global enable set and cleared by instructions; blocks all requests
// R10 - timer a: 8-bit up counter, overflows after 256 minus count
// R11 - timer b low byte: 8-bit up counter, 256 minus count alone
// R12 - upper enable chains high byte; overflow after 65536 minus value
// R13 - carrier timer is an up timer unless both mode bits are set
// R14 - carrier half period is (1 plus value) times carrier scale
// R15 - low segment lasts (1 plus low width) times low scale
// R16 - high segment lasts (1 plus high width) times high scale
// R17 - low-time underflow interrupt uses vector 015h
// R18 - high-time underflow interrupt uses vector 012h
// R19 - infrared disabled: modulator off, output high, carrier timer counts up
// R20 - carrier scale 1:1 when disabled, else 1:2 to 1:256
// R21 - high and low scales 1:1 when disabled, else 1:2 to 1:256
// R22 - flags set by hardware events, cleared by software, never set by write
// R23 - each timer advances only while its enable bit is 1
package tirpg_pkg;

  // ----------------------------------------------------------------
  // register indices
  // ----------------------------------------------------------------
  localparam logic [3:0] IDX_IR_CTRL   = 4'h0;
  localparam logic [3:0] IDX_INT_MASK  = 4'h1;
  localparam logic [3:0] IDX_TMR_A     = 4'h2;
  localparam logic [3:0] IDX_TMR_B_LO  = 4'h3;
  localparam logic [3:0] IDX_TMR_B_HI  = 4'h4;
  localparam logic [3:0] IDX_CARRIER   = 4'h5;
  localparam logic [3:0] IDX_LOW_W     = 4'h6;
  localparam logic [3:0] IDX_HIGH_W    = 4'h7;
  localparam logic [3:0] IDX_SCALE     = 4'h8;
  localparam logic [3:0] IDX_TMR_CTRL  = 4'h9;
  localparam logic [3:0] IDX_INT_FLAG  = 4'ha;
  localparam logic [3:0] IDX_INT_CTRL  = 4'hb;

  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int CS_EN_BIT   = 7;  // carrier scale enable
  localparam int CS_SEL_LSB  = 4;
  localparam int IRE_BIT     = 3;
  localparam int HF_BIT      = 2;
  localparam int LGP_BIT     = 1;
  localparam int PIN_SEL_BIT = 0;
  localparam int HS_EN_BIT   = 7;  // high-time scale
  localparam int HS_SEL_LSB  = 4;
  localparam int LS_EN_BIT   = 3;  // low-time scale
  localparam int LS_SEL_LSB  = 0;
  localparam int B_UPPER_BIT = 7;  // timer control
  localparam int B_EN_BIT    = 6;
  localparam int C_EN_BIT    = 2;
  localparam int A_EN_BIT    = 0;
  localparam int FLG_LOW     = 7;
  localparam int FLG_HIGH    = 6;
  localparam int FLG_C       = 5;
  localparam int FLG_B       = 4;
  localparam int FLG_A       = 3;
  localparam int FLG_RSVD    = 2;
  localparam int FLG_PORT    = 1;
  localparam int FLG_MAIN    = 0;

  // ----------------------------------------------------------------
  // reset values and vectors
  // ----------------------------------------------------------------
  localparam logic [7:0] RST_BYTE    = 8'h00;
  localparam logic [7:0] MASK_WR     = 8'hfb;  // bit 2 held at zero
  localparam logic [7:0] VEC_LOW     = 8'h15;
  localparam logic [7:0] VEC_HIGH    = 8'h12;
  localparam logic [7:0] VEC_NONE    = 8'h00;

  typedef enum logic [1:0] {
    WAVE_IDLE, WAVE_LOW, WAVE_HIGH, WAVE_DONE
  } tirpg_wave_t;

  // prescale mask: 1:1 when disabled, else 2^(sel+1) clocks per tick
  function automatic logic [7:0] tirpg_scale_mask(input logic en,
                                                  input logic [2:0] sel);
    logic [7:0] m;
    m = 8'h00;
    if (en) begin
      m = 8'hff >> (3'h7 - sel);
    end
    return m;
  endfunction

endpackage

// ### logic/tirpg_scaler.sv
/*
  prescaler: gives one tick per 1, 2, 4 ... 256 enabled clocks.
  assumes clr restarts the division so the first tick is a full period.
*/
`timescale 1ns/1ps
module tirpg_scaler
  import tirpg_pkg::*;
(
  // clock and reset
  input  wire logic       clk_sys,
  input  wire logic       rst_n,
  // control
  input  wire logic       en,
  input  wire logic       clr,
  input  wire logic       scale_en,
  input  wire logic [2:0] scale_sel,
  // result
  output logic            tick
);

  logic [7:0] div_r;
  logic [7:0] mask;

  // ----------------------------------------------------------------
  // divider
  // ----------------------------------------------------------------
  assign mask = tirpg_scale_mask(scale_en, scale_sel);
  assign tick = en && ((div_r & mask) == mask);

  // free divider, restarted by clr
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      div_r <= RST_BYTE;
    end else if (clr) begin
      div_r <= RST_BYTE;
    end else if (en) begin
      div_r <= div_r + 8'h01;
    end
  end

endmodule

// ### logic/tirpg_top.sv
/*
  timer group, carrier timer, high/low width generator, pin select and
  interrupt gating.
  assumes a register port master with one-cycle strobes, event inputs
  synchronous to clk_sys, and instruction pulses from the core.
*/
// Decided for this implementation: strobed register access and the address map.
`timescale 1ns/1ps
module tirpg_top
  import tirpg_pkg::*;
#(
  parameter logic [7:0] VEC_CARRIER = 8'h00,  // arbitrary default
  parameter logic [7:0] VEC_TMR_B   = 8'h00,  // arbitrary default
  parameter logic [7:0] VEC_TMR_A   = 8'h00,  // arbitrary default
  parameter logic [7:0] VEC_PORT    = 8'h00,  // arbitrary default
  parameter logic [7:0] VEC_MAIN    = 8'h00   // arbitrary default
)(
  // clock and reset
  input  wire logic       clk_sys,
  input  wire logic       rst_n,
  // register port
  input  wire logic [3:0] reg_addr,
  input  wire logic [7:0] reg_wdata,
  input  wire logic       reg_wr,
  input  wire logic       reg_rd,
  output logic [7:0]      reg_rdata,
  // core instruction pulses
  input  wire logic       enable_interrupts_instr,
  input  wire logic       disable_interrupts_instr,
  input  wire logic       int_taken,
  // other interrupt events
  input  wire logic       port_change_event,
  input  wire logic       main_timer_event,
  // port function of the shared pin
  input  wire logic       port6_bit7_data,
  input  wire logic       port6_direction_bit7,
  // shared pin
  output logic            port6_bit7_pin_o,
  output logic            port6_bit7_pin_oe,
  // interrupt to core
  output logic            int_req,
  output logic [7:0]      int_vector
);

  // ----------------------------------------------------------------
  // registers and nets
  // ----------------------------------------------------------------
  logic [7:0]  ir_modulator_control_r;
  logic [7:0]  timer_interrupt_mask_r;
  logic [7:0]  low_time_width_r;
  logic [7:0]  high_time_width_r;
  logic [7:0]  pulse_time_scale_reg_r;
  logic [7:0]  timer_control_r;
  logic [7:0]  int_flag_r;
  logic [7:0]  int_flag_nxt;
  logic        gie_r;
  logic [7:0]  rdata_r;
  logic        pin_o_r;
  logic        pin_oe_r;
  logic        int_req_r;
  logic [7:0]  int_vec_r;
  tirpg_wave_t wave_r;
  tirpg_wave_t wave_nxt;
  logic [7:0]  width_cnt_r;
  logic [7:0]  carrier_cnt_r;
  logic        carrier_r;

  logic        wr_ir, wr_a, wr_blo, wr_bhi, wr_c;
  logic        infrared_enable, carrier_mode_select, long_pulse_select;
  logic        modulator_pin_select, ir_mode;
  logic        timer_a_en, timer_b_en, carrier_en, timer_b_upper_enable;
  logic [7:0]  timer_a, timer_b_low, timer_b_high, carrier_timer;
  logic        a_carry, blo_carry, bhi_carry, c_carry;
  logic        b_overflow, carrier_tick, carrier_event;
  logic        low_tick, high_tick, low_under, high_under;
  logic        wave_switch;
  logic        mod_val;
  logic [7:0]  pending;
  logic [7:0]  events;

  // ----------------------------------------------------------------
  // field decode
  // ----------------------------------------------------------------
  assign wr_ir   = reg_wr && (reg_addr == IDX_IR_CTRL);
  assign wr_a    = reg_wr && (reg_addr == IDX_TMR_A);
  assign wr_blo  = reg_wr && (reg_addr == IDX_TMR_B_LO);
  assign wr_bhi  = reg_wr && (reg_addr == IDX_TMR_B_HI);
  assign wr_c    = reg_wr && (reg_addr == IDX_CARRIER);

  assign infrared_enable      = ir_modulator_control_r[IRE_BIT];
  assign carrier_mode_select  = ir_modulator_control_r[HF_BIT];
  assign long_pulse_select    = ir_modulator_control_r[LGP_BIT];
  assign modulator_pin_select = ir_modulator_control_r[PIN_SEL_BIT];
  assign ir_mode = carrier_mode_select && infrared_enable;  // R13
  assign timer_a_en           = timer_control_r[A_EN_BIT];
  assign timer_b_en           = timer_control_r[B_EN_BIT];
  assign carrier_en           = timer_control_r[C_EN_BIT];
  assign timer_b_upper_enable = timer_control_r[B_UPPER_BIT];

  // ----------------------------------------------------------------
  // software registers
  // ----------------------------------------------------------------
  // control, width and scale registers; mask bit 2 kept at zero
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      ir_modulator_control_r <= RST_BYTE;
      timer_interrupt_mask_r <= RST_BYTE;
      low_time_width_r       <= RST_BYTE;
      high_time_width_r      <= RST_BYTE;
      pulse_time_scale_reg_r <= RST_BYTE;
      timer_control_r        <= RST_BYTE;
    end else if (reg_wr) begin
      case (reg_addr)
        IDX_IR_CTRL:  ir_modulator_control_r <= reg_wdata;
        IDX_INT_MASK: timer_interrupt_mask_r <= reg_wdata & MASK_WR; // R6
        IDX_LOW_W:    low_time_width_r       <= reg_wdata;
        IDX_HIGH_W:   high_time_width_r      <= reg_wdata;
        IDX_SCALE:    pulse_time_scale_reg_r <= reg_wdata;
        IDX_TMR_CTRL: timer_control_r        <= reg_wdata;
        default: ;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // timer a and timer b
  // ----------------------------------------------------------------
  // timer a counts every clock while enabled
  tirpg_up_timer u_timer_a (
    .clk_sys  (clk_sys),
    .rst_n    (rst_n),
    .load     (wr_a),
    .load_val (reg_wdata),
    .inc      (timer_a_en),  // R10 R23
    .count    (timer_a),
    .carry    (a_carry)
  );

  // timer b low byte
  tirpg_up_timer u_timer_b_lo (
    .clk_sys  (clk_sys),
    .rst_n    (rst_n),
    .load     (wr_blo),
    .load_val (reg_wdata),
    .inc      (timer_b_en),  // R11 R23
    .count    (timer_b_low),
    .carry    (blo_carry)
  );

  // timer b high byte, chained on the low byte carry
  tirpg_up_timer u_timer_b_hi (
    .clk_sys  (clk_sys),
    .rst_n    (rst_n),
    .load     (wr_bhi),
    .load_val (reg_wdata),
    .inc      (blo_carry && timer_b_upper_enable),  // R12
    .count    (timer_b_high),
    .carry    (bhi_carry)
  );

  assign b_overflow = timer_b_upper_enable ? bhi_carry : blo_carry;  // R12

  // ----------------------------------------------------------------
  // carrier timer
  // ----------------------------------------------------------------
  // carrier prescaler
  tirpg_scaler u_carrier_scale (
    .clk_sys   (clk_sys),
    .rst_n     (rst_n),
    .en        (carrier_en),  // R23
    .clr       (wr_c || wr_ir),
    .scale_en  (ir_modulator_control_r[CS_EN_BIT]),  // R20
    .scale_sel (ir_modulator_control_r[CS_SEL_LSB +: 3]),
    .tick      (carrier_tick)
  );

  // up timer in plain mode, held as reload value in carrier mode
  tirpg_up_timer u_carrier (
    .clk_sys  (clk_sys),
    .rst_n    (rst_n),
    .load     (wr_c),
    .load_val (reg_wdata),
    .inc      (carrier_tick && !ir_mode),  // R13 R19
    .count    (carrier_timer),
    .carry    (c_carry)
  );

  // half period of (1 + value) scaled ticks, then the carrier toggles
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      carrier_cnt_r <= RST_BYTE;
      carrier_r     <= 1'b1;
    end else if (!ir_mode || wr_c) begin
      carrier_cnt_r <= wr_c ? reg_wdata : carrier_timer;
      carrier_r     <= 1'b1;
    end else if (carrier_tick) begin
      if (carrier_cnt_r == 8'h00) begin
        carrier_cnt_r <= carrier_timer;  // R14
        carrier_r     <= !carrier_r;
      end else begin
        carrier_cnt_r <= carrier_cnt_r - 8'h01;
      end
    end
  end

  assign carrier_event = ir_mode ? (carrier_tick && carrier_cnt_r == 8'h00)
                                 : c_carry;

  // ----------------------------------------------------------------
  // high and low width generator
  // ----------------------------------------------------------------
  // low-time prescaler, runs only in the low segment
  tirpg_scaler u_low_scale (
    .clk_sys   (clk_sys),
    .rst_n     (rst_n),
    .en        (wave_r == WAVE_LOW),
    .clr       (wave_switch),
    .scale_en  (pulse_time_scale_reg_r[LS_EN_BIT]),  // R21
    .scale_sel (pulse_time_scale_reg_r[LS_SEL_LSB +: 3]),
    .tick      (low_tick)
  );

  // high-time prescaler, runs only in the high segment
  tirpg_scaler u_high_scale (
    .clk_sys   (clk_sys),
    .rst_n     (rst_n),
    .en        (wave_r == WAVE_HIGH),
    .clr       (wave_switch),
    .scale_en  (pulse_time_scale_reg_r[HS_EN_BIT]),  // R21
    .scale_sel (pulse_time_scale_reg_r[HS_SEL_LSB +: 3]),
    .tick      (high_tick)
  );

  assign low_under  = low_tick && (width_cnt_r == 8'h00);   // R15
  assign high_under = high_tick && (width_cnt_r == 8'h00);  // R16

  // segment sequencing
  always_comb begin
    wave_nxt = wave_r;
    case (wave_r)
      WAVE_IDLE: begin
        if (infrared_enable) begin
          wave_nxt = WAVE_LOW;
        end
      end
      WAVE_LOW: begin
        if (low_under) begin
          wave_nxt = long_pulse_select ? WAVE_DONE : WAVE_HIGH;  // R3
        end
      end
      WAVE_HIGH: begin
        if (high_under) begin
          wave_nxt = WAVE_LOW;  // R1
        end
      end
      WAVE_DONE: wave_nxt = WAVE_DONE;
      default:   wave_nxt = WAVE_IDLE;
    endcase
    if (!infrared_enable) begin
      wave_nxt = WAVE_IDLE;  // R19
    end
  end

  assign wave_switch = (wave_nxt != wave_r);

  // segment state and width down counter, reloaded on each switch
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      wave_r      <= WAVE_IDLE;
      width_cnt_r <= RST_BYTE;
    end else begin
      wave_r <= wave_nxt;
      if (wave_switch) begin
        width_cnt_r <= (wave_nxt == WAVE_HIGH) ? high_time_width_r
                                               : low_time_width_r;
      end else if (low_tick || high_tick) begin
        width_cnt_r <= width_cnt_r - 8'h01;
      end
    end
  end

  // ----------------------------------------------------------------
  // modulator output and pin select
  // ----------------------------------------------------------------
  // low segment: carrier in carrier mode, else low; high otherwise
  always_comb begin
    mod_val = 1'b1;  // R19
    if (wave_r == WAVE_LOW) begin
      mod_val = ir_mode ? carrier_r : 1'b0;  // R1 R2
    end
  end

  // pin carries the modulator or the port bit; direction from port
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      pin_o_r  <= 1'b1;
      pin_oe_r <= 1'b0;
    end else begin
      pin_o_r  <= modulator_pin_select ? mod_val : port6_bit7_data;  // R4
      pin_oe_r <= !port6_direction_bit7;  // R5
    end
  end

  // ----------------------------------------------------------------
  // interrupt flags, gating and vector
  // ----------------------------------------------------------------
  assign events = {low_under, high_under, carrier_event, b_overflow,
                   a_carry, 1'b0, port_change_event, main_timer_event};

  // software write only clears; a same-cycle event wins
  always_comb begin
    int_flag_nxt = int_flag_r;
    if (reg_wr && reg_addr == IDX_INT_FLAG) begin
      int_flag_nxt = int_flag_r & reg_wdata;  // R22
    end
    int_flag_nxt = int_flag_nxt | events;  // R22
    int_flag_nxt[FLG_RSVD] = 1'b0;
  end

  // flags and global enable
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      int_flag_r <= RST_BYTE;
      gie_r      <= 1'b0;
    end else begin
      int_flag_r <= int_flag_nxt;
      if (disable_interrupts_instr || int_taken) begin
        gie_r <= 1'b0;  // R9
      end else if (enable_interrupts_instr) begin
        gie_r <= 1'b1;  // R9
      end
    end
  end

  assign pending = int_flag_r & timer_interrupt_mask_r;  // R8

  // request and priority vector
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      int_req_r <= 1'b0;
      int_vec_r <= VEC_NONE;
    end else begin
      int_req_r <= gie_r && (pending != 8'h00);  // R9
      if (pending[FLG_LOW]) begin
        int_vec_r <= VEC_LOW;  // R17
      end else if (pending[FLG_HIGH]) begin
        int_vec_r <= VEC_HIGH;  // R18
      end else if (pending[FLG_C]) begin
        int_vec_r <= VEC_CARRIER;
      end else if (pending[FLG_B]) begin
        int_vec_r <= VEC_TMR_B;
      end else if (pending[FLG_A]) begin
        int_vec_r <= VEC_TMR_A;
      end else if (pending[FLG_PORT]) begin
        int_vec_r <= VEC_PORT;
      end else if (pending[FLG_MAIN]) begin
        int_vec_r <= VEC_MAIN;
      end else begin
        int_vec_r <= VEC_NONE;
      end
    end
  end

  // ----------------------------------------------------------------
  // read port
  // ----------------------------------------------------------------
  // read data stands one cycle after the strobe, zero otherwise
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      rdata_r <= RST_BYTE;
    end else if (reg_rd) begin
      case (reg_addr)
        IDX_IR_CTRL:  rdata_r <= ir_modulator_control_r;
        IDX_INT_MASK: rdata_r <= timer_interrupt_mask_r;
        IDX_TMR_A:    rdata_r <= timer_a;
        IDX_TMR_B_LO: rdata_r <= timer_b_low;
        IDX_TMR_B_HI: rdata_r <= timer_b_high;
        IDX_CARRIER:  rdata_r <= carrier_timer;
        IDX_LOW_W:    rdata_r <= low_time_width_r;
        IDX_HIGH_W:   rdata_r <= high_time_width_r;
        IDX_SCALE:    rdata_r <= pulse_time_scale_reg_r;
        IDX_TMR_CTRL: rdata_r <= timer_control_r;
        IDX_INT_FLAG: rdata_r <= pending;  // flags seen through mask
        IDX_INT_CTRL: rdata_r <= {7'h00, gie_r};
        default:      rdata_r <= RST_BYTE;
      endcase
    end else begin
      rdata_r <= RST_BYTE;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign reg_rdata         = rdata_r;
  assign port6_bit7_pin_o  = pin_o_r;
  assign port6_bit7_pin_oe = pin_oe_r;
  assign int_req           = int_req_r;
  assign int_vector        = int_vec_r;

endmodule

// ### logic/tirpg_up_timer.sv
/*
  8-bit up timer with software load and carry out.
  assumes load and inc are synchronous one-cycle requests.
*/
`timescale 1ns/1ps
module tirpg_up_timer
  import tirpg_pkg::*;
(
  // clock and reset
  input  wire logic       clk_sys,
  input  wire logic       rst_n,
  // control
  input  wire logic       load,
  input  wire logic [7:0] load_val,
  input  wire logic       inc,
  // result
  output logic [7:0]      count,
  output logic            carry
);

  logic [7:0] count_r;

  // ----------------------------------------------------------------
  // counter
  // ----------------------------------------------------------------
  assign count = count_r;
  assign carry = inc && !load && (count_r == 8'hff);

  // load wins over increment, count holds otherwise
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      count_r <= RST_BYTE;
    end else if (load) begin
      count_r <= load_val;
    end else if (inc) begin
      count_r <= count_r + 8'h01;
    end
  end

endmodule

// ### sim/tb.sv
/* bench for tirpg_top: registers, timer overflow, pad waveform, vectors.
   assumes tirpg_load on the pad and tirpg_chk bound to the top. */
`timescale 1ns/1ps
module tb;
  import tirpg_pkg::*;
  logic       clk_sys, rst_n, reg_wr, reg_rd, ei, di, pin_o, pin_oe;
  logic       port6_bit7_data, port6_direction_bit7, int_req, pad;
  logic [3:0] reg_addr;
  logic [7:0] reg_wdata, reg_rdata, int_vector;
  int         low_run, high_run, run, n_mismatch, num_checks, n, n1;
  tirpg_top dut (.clk_sys, .rst_n, .reg_addr, .reg_wdata, .reg_wr,
    .reg_rd, .reg_rdata, .enable_interrupts_instr(ei),
    .disable_interrupts_instr(di), .int_taken(1'b0),
    .port_change_event(1'b0), .main_timer_event(1'b0),
    .port6_bit7_data, .port6_direction_bit7, .port6_bit7_pin_o(pin_o),
    .port6_bit7_pin_oe(pin_oe), .int_req, .int_vector);
  tirpg_load u_load (.clk_sys, .pin_o, .pin_oe, .pad, .low_run,
    .high_run, .run);
  initial begin
    clk_sys = 1'b0;
    forever #2 clk_sys = ~clk_sys;
  end
  task automatic chk(string s, logic [31:0] e, logic [31:0] g);
    num_checks++;
    if (g !== e) begin
      n_mismatch++;
      $display("ERROR %s expected %h seen %h", s, e, g);
    end
  endtask
  task automatic idle(int k);
    repeat (k) @(posedge clk_sys);
    #1;
  endtask
  task automatic wr(logic [3:0] a, logic [7:0] d);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(logic [3:0] a, logic [7:0] e);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    #1;
    chk("rdata", e, reg_rdata);
  endtask
  // run one timer from value v until the request shows, n counts clocks
  task automatic ovf(logic [3:0] a, logic [7:0] v, logic [7:0] c);
    wr(a, v);
    wr(IDX_TMR_CTRL, c);
    for (n = 0; int_req !== 1'b1; n++) begin
      idle(1);
      if (n > 900) begin
        n_mismatch++;
        finish_test();
      end
    end
    wr(IDX_TMR_CTRL, 8'h00);
    wr(IDX_INT_FLAG, 8'h00);
  endtask
  task automatic t_regs();
    for (int i = 0; i < 16; i++)
      rd(4'(i), 8'h00);
    wr(IDX_INT_MASK, 8'hff);
    rd(IDX_INT_MASK, MASK_WR);
    wr(IDX_TMR_A, 8'h5a);
    idle(5);
    rd(IDX_TMR_A, 8'h5a);
  endtask
  task automatic t_timers();
    wr(IDX_INT_MASK, 8'h38);
    @(posedge clk_sys);
    ei <= 1'b1;
    @(posedge clk_sys);
    ei <= 1'b0;
    ovf(IDX_TMR_A, 8'hf0, 8'h01);
    n1 = n;
    ovf(IDX_TMR_A, 8'he0, 8'h01);
    chk("timer a", n1 + 16, n);
    ovf(IDX_TMR_B_LO, 8'hf0, 8'h40);
    chk("timer b 8", n1, n);
    wr(IDX_TMR_B_HI, 8'hfe);
    ovf(IDX_TMR_B_LO, 8'hf0, 8'hc0);
    chk("timer b 16", n1 + 256, n);
    ovf(IDX_CARRIER, 8'hf0, 8'h04);
    chk("carrier up", n1, n);
    wr(IDX_INT_FLAG, 8'hff);
    rd(IDX_INT_FLAG, 8'h00);
  endtask
  task automatic t_wave();
    port6_direction_bit7 <= 1'b0;
    wr(IDX_LOW_W, 8'h03);
    wr(IDX_HIGH_W, 8'h05);
    wr(IDX_IR_CTRL, 8'h09);
    idle(40);
    chk("low run", 4, low_run);
    chk("high run", 6, high_run);
    wr(IDX_SCALE, 8'h08);
    idle(40);
    chk("scaled low", 8, low_run);
    wr(IDX_IR_CTRL, 8'h01);
    wr(IDX_SCALE, 8'h00);
    wr(IDX_LOW_W, 8'h02);
    wr(IDX_HIGH_W, 8'h09);
    chk("pad off", 1, pad);
    wr(IDX_IR_CTRL, 8'h0b);
    idle(150);
    chk("single low", 3, low_run);
    chk("held high", 1, run > 100);
    wr(IDX_IR_CTRL, 8'h01);
    wr(IDX_CARRIER, 8'h01);
    wr(IDX_LOW_W, 8'hff);
    wr(IDX_IR_CTRL, 8'h0d);
    wr(IDX_TMR_CTRL, 8'h04);
    idle(30);
    chk("carrier low", 2, low_run);
    chk("carrier high", 2, high_run);
    wr(IDX_IR_CTRL, 8'h00);
    idle(3);
    chk("port pin", 0, pad);
  endtask
  task automatic t_irq();
    wr(IDX_TMR_CTRL, 8'h00);
    wr(IDX_LOW_W, 8'h03);
    wr(IDX_INT_FLAG, 8'h00);
    wr(IDX_INT_MASK, 8'hc0);
    wr(IDX_IR_CTRL, 8'h09);
    idle(30);
    chk("vector low", VEC_LOW, int_vector);
    wr(IDX_INT_MASK, 8'h40);
    idle(3);
    chk("vector high", VEC_HIGH, int_vector);
    di <= 1'b1;
    idle(1);
    di <= 1'b0;
    idle(2);
    chk("req off", 0, int_req);
  endtask
  task automatic finish_test();
    $display("checks %0d mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  // reset, then the scenarios in order
  initial begin
    {reg_wr, reg_rd, ei, di, port6_bit7_data, rst_n} = '0;
    {reg_addr, reg_wdata, n_mismatch, num_checks} = '0;
    port6_direction_bit7 = 1'b1;
    repeat (4) @(posedge clk_sys);
    rst_n <= 1'b1;
    t_regs();
    t_timers();
    t_wave();
    t_irq();
    finish_test();
  end
endmodule

// ### sim/tirpg_chk_sva.sv
/* checker on the ports of tirpg_top, bound to every instance.
   assumes the register map and field positions of tirpg_pkg. */
`timescale 1ns/1ps
module tirpg_chk
  import tirpg_pkg::*;
(
  // clock, reset and watched ports
  input wire logic       clk_sys,
  input wire logic       rst_n,
  input wire logic [3:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic       reg_wr,
  input wire logic       reg_rd,
  input wire logic [7:0] reg_rdata,
  input wire logic       disable_interrupts_instr,
  input wire logic       port6_direction_bit7,
  input wire logic       port6_bit7_pin_o,
  input wire logic       port6_bit7_pin_oe,
  input wire logic       int_req,
  input wire logic [7:0] int_vector
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  logic [7:0] msk_r;
  logic [7:0] ctl_r;
  // shadow copies of the mask and control registers
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      msk_r <= 8'h00;
      ctl_r <= 8'h00;
    end else if (reg_wr) begin
      if (reg_addr == IDX_INT_MASK) msk_r <= reg_wdata & MASK_WR;
      if (reg_addr == IDX_IR_CTRL) ctl_r <= reg_wdata;
    end
  end
  sequence s_mask_rd;
    reg_rd && reg_addr == IDX_INT_MASK;
  endsequence
  sequence s_ir_off;
    (ctl_r[PIN_SEL_BIT] && !ctl_r[IRE_BIT])[*3];
  endsequence
  property p_mask_rd;
    s_mask_rd |=> reg_rdata == msk_r;
  endproperty
  a_mask_rd: assert property (p_mask_rd) else $error("mask read");
  property p_rsvd;
    s_mask_rd |=> !reg_rdata[FLG_RSVD];
  endproperty
  a_rsvd: assert property (p_rsvd) else $error("mask bit 2 set");
  property p_masked;
    msk_r == 8'h00 && $past(msk_r) == 8'h00 |-> !int_req;
  endproperty
  a_masked: assert property (p_masked) else $error("masked req");
  property p_disable;
    disable_interrupts_instr |-> ##2 !int_req;
  endproperty
  a_disable: assert property (p_disable) else $error("req kept");
  property p_vec_low;
    int_vector == VEC_LOW |-> $past(msk_r[FLG_LOW]);
  endproperty
  a_vec_low: assert property (p_vec_low) else $error("low vector");
  property p_vec_high;
    int_vector == VEC_HIGH |-> $past(msk_r[FLG_HIGH]);
  endproperty
  a_vec_high: assert property (p_vec_high) else $error("hi vector");
  property p_ir_off;
    s_ir_off |-> port6_bit7_pin_o;
  endproperty
  a_ir_off: assert property (p_ir_off) else $error("pin not high");
  property p_oe;
    1'b1 |=> port6_bit7_pin_oe == !$past(port6_direction_bit7);
  endproperty
  a_oe: assert property (p_oe) else $error("pin enable");
endmodule
bind tirpg_top tirpg_chk u_chk (
  .clk_sys, .rst_n, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
  .disable_interrupts_instr, .port6_direction_bit7, .port6_bit7_pin_o,
  .port6_bit7_pin_oe, .int_req, .int_vector);

// ### sim/tirpg_load.sv
/* load on the shared pin: resolves the pad and times its runs.
   assumes a pull-up holds the pad high while the pin is released. */
`timescale 1ns/1ps
module tirpg_load (
  // pad drivers
  input  wire logic clk_sys,
  input  wire logic pin_o,
  input  wire logic pin_oe,
  // pad level and run lengths in clocks
  output wire logic pad,
  output int        low_run,
  output int        high_run,
  output int        run
);
  logic prv = 1'b1;
  assign pad = pin_oe ? pin_o : 1'b1;
  // close a run on every change of level
  always @(posedge clk_sys) begin
    prv <= pad;
    run <= (pad !== prv) ? 1 : run + 1;
    if (pad !== prv && prv) high_run <= run;
    if (pad !== prv && !prv) low_run <= run;
  end
endmodule
